// *** hdl/pmie_core.sv ***
`timescale 1ns/100ps
`default_nettype none
// Function
// - Call pushes PC and status, jumps
// - Clear accumulator sets it to zero
// - Clear carry forces carry to zero
// - Separate clears for user and command flags
// - Complement accumulator is one's complement
// - Flag complements invert only their bit
// - Decimal adjust adds six to low digit
// - Then high digit adjust sets carry
// - Decrement accumulator wraps modulo 256
// - Disabled input interrupt keeps request pending
// - Input full flag independent of interrupt
// - Timer disable clears request, flag still sets
// - Decrement and jump if nonzero
// - DMA enable repurposes port 2 bits 6,7
// - Acknowledge forces select, address low, clears request
// - Flag enable drives buffer flags onto port 2
// - Zero in port bit disables flag pin
// - Enabled input interrupt starts on host write
// - Enabled timer interrupt starts on overflow
// - Buffer read loads accumulator, clears full flag
// - Port input takes two cycles
module pmie_core
(
	input wire logic clk,
	input wire logic reset,
	input wire logic insn_valid,
	input wire logic [7:0] insn_opcode,
	input wire logic [7:0] insn_operand,
	input wire logic [7:0] port1_in,
	input wire logic [7:0] port2_in,
	input wire logic host_cs_n,
	input wire logic host_wr_n,
	input wire logic host_address_bit,
	input wire logic [7:0] host_data,
	input wire logic timer_overflow,
	input wire logic output_buffer_full_flag,
	input wire logic irq_taken,
	output logic insn_ready_ff,
	output logic [7:0] acc_ff,
	output logic [7:0] processor_status_word_ff,
	output logic [9:0] pc_ff,
	output logic input_buffer_full_flag_ff,
	output logic command_data_flag_ff,
	output logic timer_flag_ff,
	output logic ibf_irq_ff,
	output logic timer_irq_ff,
	output logic dma_request_out_ff,
	output logic [7:0] port2_out_ff,
	output logic port2_bit4_pin_ff,
	output logic port2_bit5_pin_ff,
	output logic port2_bit6_pin_ff
);
	import pmie_pkg::*;
	pmie_state_e state_ff;
	pmie_state_e nxt_state;
	logic [7:0] op_ff;
	logic [7:0] arg_ff;
	logic [9:0] stack_ff [STACK_DEPTH];
	logic [3:0] stack_psw_ff [STACK_DEPTH];
	logic [7:0] regs_ff [NUM_REGS];
	logic ibf_en_ff;
	logic tmr_en_ff;
	logic ibf_pend_ff;
	logic dma_en_ff;
	logic flags_en_ff;
	logic [7:0] host_in_ff;
	logic go;
	logic fin;
	logic [7:0] op;
	logic [7:0] da_acc;
	logic da_c;
	logic wr_pulse;
	logic wr_a0;
	logic [7:0] wr_data;
	logic [2:0] rsel;
	logic [7:0] rdec;
	logic [2:0] sp;
	logic [9:0] decrement_jump_nonzero_base;
	logic is_call;
	logic is_inp;
	logic is_decrement_jump_nonzero;
	logic is_decr;
	logic ack_active;

	pmie_bcd_adjust u_bcd
	(
		.acc_in(acc_ff),
		.carry_in(processor_status_word_ff[PSW_C]),
		.aux_carry_in(processor_status_word_ff[PSW_AC]),
		.acc_out(da_acc),
		.carry_out(da_c)
	);

	pmie_host_if u_host
	(
		.clk(clk),
		.reset(reset),
		.host_cs_n(host_cs_n),
		.host_wr_n(host_wr_n),
		.host_address_bit(host_address_bit),
		.host_data(host_data),
		.dma_enable(dma_en_ff),
		.dma_acknowledge_in_n(port2_in[7]),
		.write_pulse(wr_pulse),
		.write_a0(wr_a0),
		.write_data(wr_data)
	);

	// Decode helpers
	assign go = insn_valid && insn_ready_ff && (state_ff == PMIE_FETCH);
	assign op = go ? insn_opcode : op_ff;
	assign is_call = (op & MSK_CALL) == OP_CALL;
	assign is_inp = ((op & MSK_INP) == OP_IN_P) && (op[1:0] != 2'b00);
	assign is_decrement_jump_nonzero = (op & MSK_REG) == OP_DECREMENT_JUMP_NONZERO;
	assign is_decr = (op & MSK_REG) == OP_DEC_R;
	assign rsel = op[2:0];
	assign rdec = regs_ff[rsel] - 8'h01;
	assign sp = processor_status_word_ff[2:0];
	assign ack_active = dma_en_ff && !port2_in[7];
	// Page of the second byte for a page-end jump
	assign decrement_jump_nonzero_base = pc_ff + 10'h001;
	// Second cycle done for two-cycle instructions
	assign fin = (state_ff == PMIE_EXEC2);

	// Sequencer, two-cycle instructions pass through EXEC2 and HOLD
	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			PMIE_FETCH:
				if (go && (is_call || is_inp || is_decrement_jump_nonzero))
					nxt_state = PMIE_EXEC2;
			PMIE_EXEC2:
				nxt_state = PMIE_HOLD;
			PMIE_HOLD:
				nxt_state = PMIE_FETCH;
		endcase
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state_ff <= PMIE_FETCH;
			op_ff <= 8'h00;
			arg_ff <= 8'h00;
			insn_ready_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			insn_ready_ff <= (nxt_state == PMIE_FETCH);
			if (go)
			begin
				op_ff <= insn_opcode;
				arg_ff <= insn_operand;
			end
		end
	end

	// Accumulator updates
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			acc_ff <= ACC_RST;
		else if (go)
		begin
			unique case (insn_opcode)
				OP_CLR_A: acc_ff <= 8'h00;
				OP_CPL_A: acc_ff <= ~acc_ff;
				OP_DA_A: acc_ff <= da_acc;
				OP_DEC_A: acc_ff <= acc_ff - 8'h01;
				OP_IN_DBB: acc_ff <= host_in_ff;
				default: acc_ff <= acc_ff;
			endcase
		end
		else if (fin && is_inp)
			acc_ff <= (op_ff[1:0] == 2'b01) ? port1_in : port2_in;
	end

	// Status word: carry, flags, stack pointer
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			processor_status_word_ff <= PSW_RST;
		else if (go)
		begin
			unique case (insn_opcode)
				OP_CLR_C: processor_status_word_ff[PSW_C] <= 1'b0;
				OP_CPL_C: processor_status_word_ff[PSW_C] <= ~processor_status_word_ff[PSW_C];
				OP_CLR_F0: processor_status_word_ff[PSW_F0] <= 1'b0;
				OP_CPL_F0: processor_status_word_ff[PSW_F0] <= ~processor_status_word_ff[PSW_F0];
				OP_DA_A: processor_status_word_ff[PSW_C] <= da_c;
				default: processor_status_word_ff <= processor_status_word_ff;
			endcase
		end
		else if (fin && is_call)
			processor_status_word_ff[2:0] <= sp + 3'h1;
	end

	// Command/data flag, set by host address on write
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			command_data_flag_ff <= 1'b0;
		else if (wr_pulse)
			command_data_flag_ff <= wr_a0;
		else if (go && insn_opcode == OP_CLR_F1)
			command_data_flag_ff <= 1'b0;
		else if (go && insn_opcode == OP_CPL_F1)
			command_data_flag_ff <= ~command_data_flag_ff;
	end

	// Stack push on call
	always_ff @(posedge clk)
	begin
		if (fin && is_call)
		begin
			stack_ff[sp] <= pc_ff + 10'h002;
			stack_psw_ff[sp] <= processor_status_word_ff[7:4];
		end
	end

	// Program counter
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			pc_ff <= PC_RST;
		else if (go && !(is_call || is_decrement_jump_nonzero || is_inp))
			pc_ff <= pc_ff + 10'h001;
		else if (fin && is_call)
			pc_ff <= {op_ff[6:5], arg_ff};
		else if (fin && is_decrement_jump_nonzero && (regs_ff[op_ff[2:0]] != 8'h00))
			pc_ff <= {decrement_jump_nonzero_base[9:8], arg_ff};
		else if (fin)
			pc_ff <= pc_ff + (is_inp ? 10'h001 : 10'h002);
	end

	// Working registers, decremented by two instructions
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			for (int i = 0; i < NUM_REGS; i++)
				regs_ff[i] <= 8'h00;
		end
		else if (go && is_decr)
			regs_ff[rsel] <= rdec;
		else if (go && is_decrement_jump_nonzero)
			regs_ff[rsel] <= rdec;
	end

	// Interrupt enables and configuration latches
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			ibf_en_ff <= 1'b0;
			tmr_en_ff <= 1'b0;
			dma_en_ff <= 1'b0;
			flags_en_ff <= 1'b0;
		end
		else if (go)
		begin
			if (insn_opcode == OP_EN_I) ibf_en_ff <= 1'b1;
			if (insn_opcode == OP_DISABLE_INPUT_BUFFER_IRQ) ibf_en_ff <= 1'b0;
			if (insn_opcode == OP_EN_TI) tmr_en_ff <= 1'b1;
			if (insn_opcode == OP_DIS_TI) tmr_en_ff <= 1'b0;
			if (insn_opcode == OP_EN_DMA) dma_en_ff <= 1'b1;
			if (insn_opcode == OP_EN_FLAGS) flags_en_ff <= 1'b1;
		end
	end

	// Input buffer and full flag, set wins over read clear
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			host_in_ff <= 8'h00;
			input_buffer_full_flag_ff <= 1'b0;
		end
		else if (wr_pulse)
		begin
			host_in_ff <= wr_data;
			input_buffer_full_flag_ff <= 1'b1;
		end
		else if (go && insn_opcode == OP_IN_DBB)
			input_buffer_full_flag_ff <= 1'b0;
	end

	// Input buffer interrupt, held pending while disabled
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			ibf_pend_ff <= 1'b0;
			ibf_irq_ff <= 1'b0;
		end
		else
		begin
			if (wr_pulse)
				ibf_pend_ff <= 1'b1;
			else if (ibf_irq_ff && irq_taken)
				ibf_pend_ff <= 1'b0;
			ibf_irq_ff <= ibf_en_ff && (ibf_pend_ff || wr_pulse) && !(ibf_irq_ff && irq_taken);
		end
	end

	// Timer flag and request, a disable beats a same-cycle overflow
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			timer_flag_ff <= 1'b0;
			timer_irq_ff <= 1'b0;
		end
		else
		begin
			if (timer_overflow)
				timer_flag_ff <= 1'b1;
			if (go && insn_opcode == OP_DIS_TI)
				timer_irq_ff <= 1'b0;
			else if (timer_overflow && tmr_en_ff)
				timer_irq_ff <= 1'b1;
			else if (irq_taken)
				timer_irq_ff <= 1'b0;
		end
	end

	// DMA request, set by the DMA enable instruction, cleared by acknowledge
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			dma_request_out_ff <= 1'b0;
		else if (ack_active)
			dma_request_out_ff <= 1'b0;
		else if (go && insn_opcode == OP_EN_DMA)
			dma_request_out_ff <= 1'b1;
	end

	// Port 2 latch and repurposed pins
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			port2_out_ff <= PORT2_RST;
			port2_bit4_pin_ff <= 1'b1;
			port2_bit5_pin_ff <= 1'b1;
			port2_bit6_pin_ff <= 1'b1;
		end
		else
		begin
			port2_bit4_pin_ff <= (flags_en_ff && port2_out_ff[4]) ? output_buffer_full_flag
				: port2_out_ff[4];
			port2_bit5_pin_ff <= (flags_en_ff && port2_out_ff[5]) ? !input_buffer_full_flag_ff
				: port2_out_ff[5];
			port2_bit6_pin_ff <= dma_en_ff ? dma_request_out_ff : port2_out_ff[6];
		end
	end
endmodule : pmie_core
`default_nettype wire

// *** hdl/pmie_pkg.sv ***
package pmie_pkg;
	// Opcodes of the covered instructions
	localparam logic [7:0] OP_CLR_A = 8'h27;
	localparam logic [7:0] OP_CLR_C = 8'h97;
	localparam logic [7:0] OP_CLR_F1 = 8'ha5;
	localparam logic [7:0] OP_CLR_F0 = 8'h85;
	localparam logic [7:0] OP_CPL_A = 8'h37;
	localparam logic [7:0] OP_CPL_C = 8'ha7;
	localparam logic [7:0] OP_CPL_F0 = 8'h95;
	localparam logic [7:0] OP_CPL_F1 = 8'hb5;
	localparam logic [7:0] OP_DA_A = 8'h57;
	localparam logic [7:0] OP_DEC_A = 8'h07;
	localparam logic [7:0] OP_DISABLE_INPUT_BUFFER_IRQ = 8'h15;
	localparam logic [7:0] OP_DIS_TI = 8'h35;
	localparam logic [7:0] OP_EN_DMA = 8'he5;
	localparam logic [7:0] OP_EN_FLAGS = 8'hf5;
	localparam logic [7:0] OP_EN_I = 8'h05;
	localparam logic [7:0] OP_EN_TI = 8'h25;
	localparam logic [7:0] OP_IN_DBB = 8'h22;
	// Masked opcode groups
	localparam logic [7:0] MSK_CALL = 8'h1f;
	localparam logic [7:0] OP_CALL = 8'h14;
	localparam logic [7:0] MSK_REG = 8'hf8;
	localparam logic [7:0] OP_DEC_R = 8'hc8;
	localparam logic [7:0] OP_DECREMENT_JUMP_NONZERO = 8'he8;
	localparam logic [7:0] MSK_INP = 8'hfc;
	localparam logic [7:0] OP_IN_P = 8'h08;
	// Status word fields
	localparam int PSW_C = 7;
	localparam int PSW_AC = 6;
	localparam int PSW_F0 = 5;
	localparam logic [7:0] PSW_RST = 8'h08;
	// Reset values, BCD digit constants and sizes
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [9:0] PC_RST = 10'h000;
	localparam logic [7:0] PORT2_RST = 8'hff;
	localparam logic [3:0] BCD_NINE = 4'h9;
	localparam logic [3:0] BCD_SIX = 4'h6;
	localparam int STACK_DEPTH = 8;
	localparam int NUM_REGS = 8;
	typedef enum logic [1:0]
	{
		PMIE_FETCH = 2'b00,
		PMIE_EXEC2 = 2'b01,
		PMIE_HOLD = 2'b10
	} pmie_state_e;
endpackage : pmie_pkg

// *** hdl/pmie_bcd_adjust.sv ***
`timescale 1ns/100ps
`default_nettype none
// Decimal adjust of the accumulator
module pmie_bcd_adjust
(
	input wire logic [7:0] acc_in,
	input wire logic carry_in,
	input wire logic aux_carry_in,
	output logic [7:0] acc_out,
	output logic carry_out
);
	import pmie_pkg::*;
	logic [8:0] step1;
	logic [4:0] hi_sum;
	// Low nibble correction adds six to whole byte
	always_comb
	begin
		if ((acc_in[3:0] > BCD_NINE) || aux_carry_in)
			step1 = {1'b0, acc_in} + {5'h00, BCD_SIX};
		else
			step1 = {1'b0, acc_in};
	end
	// High nibble correction and carry out
	always_comb
	begin
		if ((step1[7:4] > BCD_NINE) || carry_in || step1[8])
			hi_sum = {1'b0, step1[7:4]} + {1'b0, BCD_SIX};
		else
			hi_sum = {1'b0, step1[7:4]};
		acc_out = {hi_sum[3:0], step1[3:0]};
		carry_out = hi_sum[4] | step1[8];
	end
endmodule : pmie_bcd_adjust
`default_nettype wire

// *** hdl/pmie_host_if.sv ***
`timescale 1ns/100ps
`default_nettype none
// Host write capture with DMA acknowledge override
module pmie_host_if
(
	input wire logic clk,
	input wire logic reset,
	input wire logic host_cs_n,
	input wire logic host_wr_n,
	input wire logic host_address_bit,
	input wire logic [7:0] host_data,
	input wire logic dma_enable,
	input wire logic dma_acknowledge_in_n,
	output logic write_pulse,
	output logic write_a0,
	output logic [7:0] write_data
);
	import pmie_pkg::*;
	logic cs_eff_n;
	logic a0_eff;
	logic wr_d_ff;
	// Acknowledge forces chip select and address low
	assign cs_eff_n = (dma_enable && !dma_acknowledge_in_n) ? 1'b0 : host_cs_n;
	assign a0_eff = (dma_enable && !dma_acknowledge_in_n) ? 1'b0 : host_address_bit;
	// Previous strobe level for edge detect
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			wr_d_ff <= 1'b0;
		else
			wr_d_ff <= !host_wr_n && !cs_eff_n;
	end
	// One pulse at start of a selected write
	assign write_pulse = !host_wr_n && !cs_eff_n && !wr_d_ff;
	assign write_a0 = a0_eff;
	assign write_data = host_data;
endmodule : pmie_host_if
`default_nettype wire

// *** test/pmie_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
// Port-level timing checks of the execution core
module pmie_monitor
(
	input wire logic clk,
	input wire logic reset,
	input wire logic insn_valid,
	input wire logic insn_ready_ff,
	input wire logic [7:0] insn_opcode,
	input wire logic [7:0] insn_operand,
	input wire logic [7:0] port1_in,
	input wire logic [7:0] port2_in,
	input wire logic timer_overflow,
	input wire logic [7:0] acc_ff,
	input wire logic [7:0] processor_status_word_ff,
	input wire logic [9:0] pc_ff,
	input wire logic timer_flag_ff,
	input wire logic timer_irq_ff,
	input wire logic dma_request_out_ff
);
	import pmie_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	// Instruction accepted at this edge
	wire logic take = insn_valid && insn_ready_ff;
	sequence s_call;
		take && ((insn_opcode & MSK_CALL) == OP_CALL);
	endsequence
	sequence s_call_done;
		s_call ##2 1'b1;
	endsequence
	a_clear_acc: assert property (take && insn_opcode == OP_CLR_A |=> acc_ff == 8'h00)
		else $error("accumulator not cleared");
	a_cpl_acc: assert property (take && insn_opcode == OP_CPL_A |=> acc_ff == ~$past(acc_ff))
		else $error("accumulator not inverted");
	a_cpl_carry: assert property (take && insn_opcode == OP_CPL_C |=>
		processor_status_word_ff == ($past(processor_status_word_ff) ^ 8'h80))
		else $error("carry complement touched other bits");
	a_call_target: assert property (s_call_done |-> pc_ff ==
		{$past(insn_opcode[6:5], 2), $past(insn_operand, 2)} &&
		processor_status_word_ff[2:0] == $past(processor_status_word_ff[2:0], 2) + 3'h1)
		else $error("call target or stack pointer wrong");
	a_port_read: assert property (take && insn_opcode == (OP_IN_P | 8'h01) |=>
		##1 acc_ff == $past(port1_in))
		else $error("port read wrong");
	a_timer_flag: assert property (timer_overflow |=> timer_flag_ff)
		else $error("overflow did not set timer flag");
	a_timer_off: assert property (take && insn_opcode == OP_DIS_TI |=>
		!timer_irq_ff)
		else $error("timer request survived disable");
	a_dma_clear: assert property (dma_request_out_ff && !port2_in[7] |->
		##[1:3] !dma_request_out_ff)
		else $error("acknowledge did not clear request");
endmodule : pmie_monitor
bind pmie_core pmie_monitor u_mon (.clk, .reset, .insn_valid, .insn_ready_ff, .insn_opcode,
	.insn_operand, .port1_in, .port2_in, .timer_overflow, .acc_ff, .processor_status_word_ff,
	.pc_ff, .timer_flag_ff, .timer_irq_ff, .dma_request_out_ff);
`default_nettype wire

// *** test/pmie_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// Master processor writing the host data buffer
module pmie_host_model
(
	input wire logic clk,
	output logic host_cs_n,
	output logic host_wr_n,
	output logic host_address_bit,
	output logic [7:0] host_data
);
	// Idle bus
	initial
	begin
		host_cs_n = 1'b1;
		host_wr_n = 1'b1;
		host_address_bit = 1'b0;
		host_data = 8'h00;
	end
	// One write; afterwards select is high, address and data show the inverse of the last value
	task automatic write(input logic a0, input logic [7:0] d, input logic sel_n);
		@(posedge clk);
		host_cs_n <= sel_n;
		host_address_bit <= a0;
		host_data <= d;
		@(posedge clk);
		host_wr_n <= 1'b0;
		repeat (2) @(posedge clk);
		host_wr_n <= 1'b1;
		@(posedge clk);
		host_cs_n <= 1'b1;
		host_address_bit <= ~a0;
		host_data <= ~d;
	endtask : write
endmodule : pmie_host_model
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the execution core
module tb_top;
	import pmie_pkg::*;
	logic clk, reset, insn_valid, timer_overflow, output_buffer_full_flag, irq_taken;
	logic [7:0] insn_opcode, insn_operand, port1_in, port2_in, acc, processor_status_word, p2o, d;
	logic rdy, input_buffer_full_flag, cdf, tfl, iirq, tirq, dma_request_out, pin4, pin5, pin6;
	logic [9:0] pc;
	wire logic cs_n, wr_n, a0;
	wire logic [7:0] hd;
	int bad_count, checks_done, seed, m_acc, m_c, m_f0, m_f1, m_sp, m_pc, m_rv, i, k, r, t, j;
	logic [7:0] ops [10] = '{OP_CLR_A, OP_CPL_A, OP_DEC_A, OP_DA_A, OP_CLR_C, OP_CPL_C,
		OP_CLR_F0, OP_CPL_F0, OP_CLR_F1, OP_CPL_F1};
	pmie_core u_dut (.clk(clk), .reset(reset), .insn_valid(insn_valid),
		.insn_opcode(insn_opcode), .insn_operand(insn_operand), .port1_in(port1_in),
		.port2_in(port2_in), .host_cs_n(cs_n), .host_wr_n(wr_n), .host_address_bit(a0),
		.host_data(hd), .timer_overflow(timer_overflow),
		.output_buffer_full_flag(output_buffer_full_flag), .irq_taken(irq_taken),
		.insn_ready_ff(rdy), .acc_ff(acc), .processor_status_word_ff(processor_status_word), .pc_ff(pc),
		.input_buffer_full_flag_ff(input_buffer_full_flag), .command_data_flag_ff(cdf), .timer_flag_ff(tfl),
		.ibf_irq_ff(iirq), .timer_irq_ff(tirq), .dma_request_out_ff(dma_request_out),
		.port2_out_ff(p2o), .port2_bit4_pin_ff(pin4), .port2_bit5_pin_ff(pin5),
		.port2_bit6_pin_ff(pin6));
	pmie_host_model u_host (.clk(clk), .host_cs_n(cs_n), .host_wr_n(wr_n),
		.host_address_bit(a0), .host_data(hd));
	// 40 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask : check
	// Bounded wait for the ready window
	task automatic wait_rdy();
		k = 0;
		do
		begin
			@(negedge clk);
			k++;
		end
		while (rdy !== 1'b1 && k < 20);
		check(k < 20, 1'b1);
	endtask : wait_rdy
	task automatic exec(input logic [7:0] op, input logic [7:0] arg);
		wait_rdy();
		@(posedge clk);
		insn_opcode <= op;
		insn_operand <= arg;
		insn_valid <= 1'b1;
		@(posedge clk);
		insn_valid <= 1'b0;
		wait_rdy();
	endtask : exec
	// Accumulator and flag ops against the model
	task automatic alu(input logic [7:0] op);
		exec(op, 8'h00);
		case (op)
			OP_CLR_A: m_acc = 0;
			OP_CPL_A: m_acc = 255 - m_acc;
			OP_DEC_A: m_acc = (m_acc + 255) % 256;
			OP_CLR_C: m_c = 0;
			OP_CPL_C: m_c = 1 - m_c;
			OP_CLR_F0: m_f0 = 0;
			OP_CPL_F0: m_f0 = 1 - m_f0;
			OP_CLR_F1: m_f1 = 0;
			OP_CPL_F1: m_f1 = 1 - m_f1;
			default:
			begin
				if (m_acc % 16 > 9)
					m_acc += 6;
				if (m_acc / 16 > 9 || m_c == 1)
					m_acc += 96;
				m_c = m_acc / 256;
				m_acc %= 256;
			end
		endcase
		check(acc, m_acc);
		check(processor_status_word[7:5], {m_c[0], 1'b0, m_f0[0]});
		check(cdf, m_f1);
	endtask : alu
	// One decrement-and-jump with a random target
	task automatic decrement_jump_nonzero(output int jumped);
		int nxt;
		nxt = (m_pc % 256 == 255) ? (m_pc / 256 + 1) % 4 * 256 : m_pc / 256 * 256;
		nxt += {$random(seed)} % 256;
		nxt ^= (nxt == (m_pc + 2) % 1024);
		exec(OP_DECREMENT_JUMP_NONZERO | 8'(r), 8'(nxt % 256));
		m_rv = (m_rv + 255) % 256;
		jumped = (pc === 10'(nxt));
		m_pc = (m_rv != 0) ? nxt : (m_pc + 2) % 1024;
		check(pc, m_pc);
	endtask : decrement_jump_nonzero
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done
	// Cuts a hung run short
	initial
	begin
		#(25 * 20000);
		bad_count++;
		test_done();
	end
	// Main sequence
	initial
	begin
		seed = 32'h4224ec7f;
		reset = 1'b1;
		insn_valid = 1'b0;
		insn_opcode = 8'h00;
		insn_operand = 8'h00;
		port1_in = 8'h00;
		port2_in = 8'hff;
		timer_overflow = 1'b0;
		output_buffer_full_flag = 1'b0;
		irq_taken = 1'b0;
		repeat (8) @(posedge clk);
		check(processor_status_word, 8'h08);
		check({p2o, pin4, pin5}, 10'h3ff);
		reset <= 1'b0;
		alu(OP_CLR_A);
		alu(OP_DEC_A);
		for (i = 0; i < 40; i++)
		begin
			r = {$random(seed)} % 10;
			if (r < 4)
			begin
				@(posedge clk);
				port1_in <= 8'($random(seed));
				port2_in <= 8'($random(seed)) | 8'h80;
				exec(OP_IN_P | 8'(r % 2 + 1), 8'h00);
				m_acc = (r % 2) ? port2_in : port1_in;
				check(acc, m_acc);
			end
			if (ops[r] == OP_DA_A && m_acc > 239)
				r = 1;
			alu(ops[r]);
		end
		$display("test alu done");
		for (i = 0; i < 3; i++)
		begin
			t = (i == 2) ? 767 : {$random(seed)} % 1024;
			exec(OP_CALL | 8'(t / 256 * 32), 8'(t));
			m_sp++;
			m_pc = t;
			check(pc, m_pc);
			check(processor_status_word[2:0], m_sp);
		end
		r = {$random(seed)} % 8;
		j = 1;
		for (i = 0; i < 300 && j == 1; i++)
			decrement_jump_nonzero(j);
		check(j, 0);
		exec(OP_DEC_R | 8'(r), 8'h00);
		m_rv = (m_rv + 255) % 256;
		m_pc = (m_pc + 1) % 1024;
		for (i = 0; i < 255; i++)
		begin
			decrement_jump_nonzero(j);
			check(j, i < 254);
		end
		$display("test branch done");
		exec(OP_EN_I, 8'h00);
		d = 8'($random(seed));
		u_host.write(1'b1, d, 1'b0);
		repeat (2) @(negedge clk);
		check({input_buffer_full_flag, cdf, iirq}, 3'b111);
		@(posedge clk);
		irq_taken <= 1'b1;
		@(posedge clk);
		irq_taken <= 1'b0;
		exec(OP_IN_DBB, 8'h00);
		check({acc, input_buffer_full_flag, iirq}, {d, 2'b00});
		exec(OP_DISABLE_INPUT_BUFFER_IRQ, 8'h00);
		u_host.write(1'b0, ~d, 1'b0);
		repeat (2) @(negedge clk);
		check({input_buffer_full_flag, cdf, iirq}, 3'b100);
		exec(OP_EN_I, 8'h00);
		@(negedge clk);
		check(iirq, 1'b1);
		for (i = 0; i < 2; i++)
		begin
			exec(i ? OP_DIS_TI : OP_EN_TI, 8'h00);
			check(tirq, 1'b0);
			@(posedge clk);
			timer_overflow <= 1'b1;
			@(posedge clk);
			timer_overflow <= 1'b0;
			repeat (2) @(negedge clk);
			check({tfl, tirq}, {1'b1, i == 0});
		end
		$display("test host and timer done");
		exec(OP_IN_DBB, 8'h00);
		exec(OP_EN_DMA, 8'h00);
		check({dma_request_out, pin6}, 2'b11);
		@(posedge clk);
		port2_in <= 8'h7f;
		repeat (3) @(negedge clk);
		check({dma_request_out, pin6}, 2'b00);
		u_host.write(1'b1, d, 1'b1);
		repeat (2) @(negedge clk);
		check({input_buffer_full_flag, cdf}, 2'b10);
		@(posedge clk);
		port2_in <= 8'hff;
		exec(OP_EN_FLAGS, 8'h00);
		for (i = 0; i < 2; i++)
		begin
			@(posedge clk);
			output_buffer_full_flag <= i[0];
			repeat (2) @(negedge clk);
			check({pin4, pin5}, {2{i[0]}});
			exec(OP_IN_DBB, 8'h00);
		end
		$display("test dma and flags done");
		test_done();
	end
endmodule : tb_top
`default_nettype wire
